// [hdl/atc_compare.sv]
`timescale 1ns/10ps
module atc_compare (
    input wire logic [1:0] compare_mode,
    input wire logic [15:0] value,
    input wire logic [15:0] thr_lo,
    input wire logic [15:0] thr_hi,
    output logic match,
    output logic hit_mirror,
    output logic repl_lo,
    output logic repl_hi
);

    logic above;
    logic below;

    always_comb begin
        above = value > thr_hi;
        below = value < thr_lo;
        match = 1'b0;
        hit_mirror = 1'b0;
        repl_lo = 1'b0;
        repl_hi = 1'b0;
        unique case (atc_pkg::atc_cmp_mode_t'(compare_mode))
            atc_pkg::CMP_LESS: begin
                match = value < thr_lo; // RULE11
                repl_lo = match;
            end
            atc_pkg::CMP_GREATER: begin
                match = value > thr_lo; // RULE11
                repl_lo = match;
            end
            atc_pkg::CMP_INSIDE: begin
                match = (thr_hi > value) && (value > thr_lo); // RULE15
                repl_lo = match;
            end
            atc_pkg::CMP_OUTSIDE: begin
                match = above | below;
                hit_mirror = above; // RULE16
                repl_hi = above; // RULE17
                repl_lo = below & ~above; // RULE17
            end
        endcase
    end

endmodule : atc_compare

// [hdl/atc_threshold.sv]
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// RULE1: Window modes pair word n with n+9.
// RULE2: Only lower channels have a real mirror.
// RULE3: Software loads thresholds only while module off.
// RULE4: Simple compares use channel's own word.
// RULE5: Window: low at channel, high at mirror.
// RULE6: Hit bits per channel, two registers. Only the low one holds hits here; the high one reads zero.
// RULE7: Hit bit sticky until software clears it.
// RULE8: One compare may set several hit bits.
// RULE9: Detect on: irq mode overrides conversion count.
// RULE10: Irq mode: scan, scan-with-match, match, never.
// RULE11: Mode 01 greater, 00 less than.
// RULE12: Simple match sets converted channel's hit.
// RULE13: Write mode 01 stores, 10 discards.
// RULE14: Software uses channel indexed storage with compares.
// RULE15: Mode 10 strictly inside window, own hit.
// RULE16: Mode 11 outside; above also sets mirror.
// RULE17: Outside store replaces the crossed threshold.
// RULE18: Detect enable gates all threshold behaviour.
// RULE19: Hardware set beats software clear.
module atc_threshold (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [6:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic conv_valid,
    input wire logic [3:0] conv_channel,
    input wire logic [15:0] conv_value,
    input wire logic scan_end,
    output logic module_on,
    output logic irq
);

    // Merges the two low write lanes into a 16-bit register.
    function automatic logic [15:0] lane_merge(
        input logic [15:0] old,
        input logic [31:0] wdata,
        input logic [3:0] be
    );
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction : lane_merge

    // Ones written in enabled lanes, used for write-one-to-clear.
    function automatic logic [15:0] lane_ones(
        input logic [31:0] wdata,
        input logic [3:0] be
    );
        logic [15:0] res;
        res = 16'h0000;
        if (be[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction : lane_ones

    function automatic logic [15:0] onehot(input logic [3:0] idx);
        logic [15:0] res;
        res = 16'h0000;
        res[idx] = 1'b1;
        return res;
    endfunction : onehot

    function automatic logic is_buf(input logic [6:0] addr);
        return addr[6] == atc_pkg::OFS_BUF[6];
    endfunction : is_buf

    logic thresh_detect_enable;
    logic [1:0] compare_mode;
    logic [1:0] write_mode;
    logic [1:0] thresh_irq_mode;
    logic indexed_buffer_enable;
    logic [4:0] conversions_per_irq;
    logic [15:0] compare_hit_low;
    logic [1:0] status;
    logic [1:0] mask;
    logic seq_match;
    logic [4:0] conv_count;
    logic ack;
    logic [15:0] result_buffer_word [atc_pkg::BUF_DEPTH];

    logic next_thresh_detect_enable;
    logic [1:0] next_compare_mode;
    logic [1:0] next_write_mode;
    logic [1:0] next_thresh_irq_mode;
    logic next_module_on;
    logic next_indexed_buffer_enable;
    logic [4:0] next_conversions_per_irq;
    logic [15:0] next_compare_hit_low;
    logic [1:0] next_status;
    logic [1:0] next_mask;
    logic next_seq_match;
    logic [4:0] next_conv_count;
    logic next_ack;
    logic [31:0] next_readdata;
    logic [15:0] next_buffer [atc_pkg::BUF_DEPTH];

    logic req;
    logic wr_fire;
    logic [15:0] ctrl_word;
    logic [31:0] rd_mux;
    logic [3:0] mirror_idx;
    logic [15:0] thr_lo;
    logic [15:0] thr_hi;
    logic match;
    logic hit_mirror;
    logic repl_lo;
    logic repl_hi;
    logic compare_active;
    logic cmp_hit;
    logic conv_evt;
    logic refused_evt;
    logic [15:0] hit_set;

    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack;
    assign wr_fire = avs_write & ack;
    assign irq = |(status & mask);

    assign ctrl_word = {2'h0, conversions_per_irq, indexed_buffer_enable, module_on,
                        thresh_irq_mode, write_mode, compare_mode, thresh_detect_enable};

    // The pair of a channel is fixed; above channel 6 the sum wraps to words 0 to 8.
    assign mirror_idx = conv_channel + atc_pkg::MIRROR_OFS; // RULE1 RULE2
    assign thr_lo = result_buffer_word[conv_channel]; // RULE4 RULE5
    assign thr_hi = result_buffer_word[mirror_idx]; // RULE5

    atc_compare u_compare (
        .compare_mode(compare_mode),
        .value(conv_value),
        .thr_lo(thr_lo),
        .thr_hi(thr_hi),
        .match(match),
        .hit_mirror(hit_mirror),
        .repl_lo(repl_lo),
        .repl_hi(repl_hi)
    );

    // Write mode 00 stores without compare, so it gets no hits.
    assign compare_active = thresh_detect_enable && (write_mode != atc_pkg::WM_LEGACY); // RULE18
    assign cmp_hit = conv_valid & compare_active & match;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (is_buf(avs_address)) begin
            rd_mux[15:0] = result_buffer_word[avs_address[5:2]];
        end else begin
            unique case (avs_address)
                atc_pkg::OFS_CTRL: rd_mux[15:0] = ctrl_word;
                atc_pkg::OFS_HIT_LOW: rd_mux[15:0] = compare_hit_low;
                atc_pkg::OFS_STATUS: rd_mux[1:0] = status;
                atc_pkg::OFS_MASK: rd_mux[1:0] = mask;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        next_ack = req & ~ack;
        next_readdata = (avs_read & ~ack) ? rd_mux : avs_readdata;
    end

    always_comb begin
        logic [15:0] nc;
        nc = ctrl_word;
        if (wr_fire && avs_address == atc_pkg::OFS_CTRL) begin
            nc = lane_merge(ctrl_word, avs_writedata, avs_byteenable);
        end
        next_thresh_detect_enable = nc[atc_pkg::POS_DETECT_EN];
        next_compare_mode = nc[atc_pkg::POS_CMP_MODE +: 2];
        next_write_mode = nc[atc_pkg::POS_WR_MODE +: 2];
        next_thresh_irq_mode = nc[atc_pkg::POS_IRQ_MODE +: 2];
        next_module_on = nc[atc_pkg::POS_MODULE_ON];
        next_indexed_buffer_enable = nc[atc_pkg::POS_INDEXED];
        next_conversions_per_irq = nc[atc_pkg::POS_CONV_PER_IRQ +: 5];
        next_mask = mask;
        if (wr_fire && avs_address == atc_pkg::OFS_MASK && avs_byteenable[0]) begin
            next_mask = avs_writedata[1:0];
        end
    end

    // Buffer: software loads thresholds, hardware stores conversions.
    always_comb begin
        refused_evt = 1'b0;
        for (int i = 0; i < atc_pkg::BUF_DEPTH; i++) begin
            next_buffer[i] = result_buffer_word[i];
        end
        if (wr_fire && is_buf(avs_address)) begin
            if (!module_on) begin
                next_buffer[avs_address[5:2]] = lane_merge(result_buffer_word[avs_address[5:2]],
                                                           avs_writedata, avs_byteenable); // RULE3
            end else begin
                refused_evt = 1'b1; // RULE3
            end
        end
        if (conv_valid && !compare_active) begin
            next_buffer[conv_channel] = conv_value;
        end else if (cmp_hit && write_mode == atc_pkg::WM_STORE) begin // RULE13
            if (repl_lo) begin
                next_buffer[conv_channel] = conv_value; // RULE12 RULE17
            end
            if (repl_hi) begin
                next_buffer[mirror_idx] = conv_value; // RULE17
            end
        end
    end

    // Hit bits: set on match, cleared by writing ones; a same-cycle set survives.
    always_comb begin
        logic [15:0] clr;
        clr = 16'h0000;
        if (wr_fire && avs_address == atc_pkg::OFS_HIT_LOW) begin
            clr = lane_ones(avs_writedata, avs_byteenable);
        end
        hit_set = 16'h0000;
        if (cmp_hit) begin
            hit_set = onehot(conv_channel); // RULE6 RULE12 RULE15
            if (hit_mirror) begin
                hit_set = hit_set | onehot(mirror_idx); // RULE8 RULE16
            end
        end
        next_compare_hit_low = (compare_hit_low & ~clr) | hit_set; // RULE7 RULE19
    end

    // Converter interrupt events, from threshold logic or the conversion count.
    always_comb begin
        conv_evt = 1'b0;
        next_seq_match = 1'b0;
        next_conv_count = conv_count;
        if (thresh_detect_enable) begin // RULE9 RULE18
            next_seq_match = scan_end ? 1'b0 : (seq_match | cmp_hit);
            unique case (atc_pkg::atc_irq_mode_t'(thresh_irq_mode)) // RULE10
                atc_pkg::IRQ_NONE: conv_evt = 1'b0;
                atc_pkg::IRQ_MATCH: conv_evt = cmp_hit;
                atc_pkg::IRQ_SEQ_MATCH: conv_evt = scan_end & (seq_match | cmp_hit);
                atc_pkg::IRQ_SEQ: conv_evt = scan_end;
            endcase
            next_conv_count = atc_pkg::RST_COUNT;
        end else if (conv_valid) begin
            if (conv_count == conversions_per_irq) begin
                conv_evt = 1'b1;
                next_conv_count = atc_pkg::RST_COUNT;
            end else begin
                next_conv_count = conv_count + 5'h01;
            end
        end
    end

    always_comb begin
        logic [1:0] clr;
        logic [1:0] set;
        clr = 2'h0;
        if (wr_fire && avs_address == atc_pkg::OFS_STATUS && avs_byteenable[0]) begin
            clr = avs_writedata[1:0];
        end
        set = 2'h0;
        set[atc_pkg::POS_ST_CONV_IRQ] = conv_evt;
        set[atc_pkg::POS_ST_REFUSED] = refused_evt;
        next_status = (status & ~clr) | set;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            thresh_detect_enable <= atc_pkg::RST_CTRL[atc_pkg::POS_DETECT_EN];
            compare_mode <= atc_pkg::RST_CTRL[atc_pkg::POS_CMP_MODE +: 2];
            write_mode <= atc_pkg::RST_CTRL[atc_pkg::POS_WR_MODE +: 2];
            thresh_irq_mode <= atc_pkg::RST_CTRL[atc_pkg::POS_IRQ_MODE +: 2];
            module_on <= atc_pkg::RST_CTRL[atc_pkg::POS_MODULE_ON];
            indexed_buffer_enable <= atc_pkg::RST_CTRL[atc_pkg::POS_INDEXED];
            conversions_per_irq <= atc_pkg::RST_CTRL[atc_pkg::POS_CONV_PER_IRQ +: 5];
            compare_hit_low <= atc_pkg::RST_HIT;
            status <= atc_pkg::RST_STATUS;
            mask <= atc_pkg::RST_MASK;
            seq_match <= 1'b0;
            conv_count <= atc_pkg::RST_COUNT;
            ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            for (int i = 0; i < atc_pkg::BUF_DEPTH; i++) begin
                result_buffer_word[i] <= atc_pkg::RST_BUF;
            end
        end else begin
            thresh_detect_enable <= next_thresh_detect_enable;
            compare_mode <= next_compare_mode;
            write_mode <= next_write_mode;
            thresh_irq_mode <= next_thresh_irq_mode;
            module_on <= next_module_on;
            indexed_buffer_enable <= next_indexed_buffer_enable;
            conversions_per_irq <= next_conversions_per_irq;
            compare_hit_low <= next_compare_hit_low;
            status <= next_status;
            mask <= next_mask;
            seq_match <= next_seq_match;
            conv_count <= next_conv_count;
            ack <= next_ack;
            avs_readdata <= next_readdata;
            for (int i = 0; i < atc_pkg::BUF_DEPTH; i++) begin
                result_buffer_word[i] <= next_buffer[i];
            end
        end
    end

endmodule : atc_threshold

// [pkg/atc_pkg.sv]
package atc_pkg;

    localparam int NUM_CH = 16;
    localparam int BUF_DEPTH = 16;
    localparam int DATA_W = 16;
    localparam int IDX_W = 4;

    // A word from 0 to 6 pairs with the word this many places above it.
    localparam logic [3:0] MIRROR_OFS = 4'h9;

    // Byte addresses on the register bus.
    localparam logic [6:0] OFS_CTRL = 7'h00;
    localparam logic [6:0] OFS_HIT_LOW = 7'h04;
    localparam logic [6:0] OFS_HIT_HIGH = 7'h08;
    localparam logic [6:0] OFS_STATUS = 7'h0c;
    localparam logic [6:0] OFS_MASK = 7'h10;
    localparam logic [6:0] OFS_BUF = 7'h40;

    // Control register fields.
    localparam int POS_DETECT_EN = 0;
    localparam int POS_CMP_MODE = 1;
    localparam int POS_WR_MODE = 3;
    localparam int POS_IRQ_MODE = 5;
    localparam int POS_MODULE_ON = 7;
    localparam int POS_INDEXED = 8;
    localparam int POS_CONV_PER_IRQ = 9;

    // Status and mask register fields.
    localparam int POS_ST_CONV_IRQ = 0;
    localparam int POS_ST_REFUSED = 1;
    localparam int STATUS_W = 2;

    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [15:0] RST_HIT = 16'h0000;
    localparam logic [15:0] RST_BUF = 16'h0000;
    localparam logic [1:0] RST_STATUS = 2'h0;
    localparam logic [1:0] RST_MASK = 2'h0;
    localparam logic [4:0] RST_COUNT = 5'h00;

    typedef enum logic [1:0] {
        CMP_LESS = 2'h0,
        CMP_GREATER = 2'h1,
        CMP_INSIDE = 2'h2,
        CMP_OUTSIDE = 2'h3
    } atc_cmp_mode_t;

    typedef enum logic [1:0] {
        WM_LEGACY = 2'h0,
        WM_STORE = 2'h1,
        WM_DISCARD = 2'h2,
        WM_RESERVED = 2'h3
    } atc_wr_mode_t;

    typedef enum logic [1:0] {
        IRQ_NONE = 2'h0,
        IRQ_MATCH = 2'h1,
        IRQ_SEQ_MATCH = 2'h2,
        IRQ_SEQ = 2'h3
    } atc_irq_mode_t;

endpackage : atc_pkg

// [tb/atc_threshold_props.sv]
`timescale 1ns/10ps
module atc_threshold_props (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [6:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic conv_valid,
    input wire logic [3:0] conv_channel,
    input wire logic [15:0] conv_value,
    input wire logic scan_end,
    input wire logic module_on,
    input wire logic irq
);
    logic [15:0] ctrl_sh, next_ctrl_sh;
    logic [1:0] mask_sh, next_mask_sh;
    logic wr_ok, rd_ok;
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign rd_ok = avs_read && !avs_waitrequest;
    // Shadow copies of control and mask, updated at the edge a write completes.
    always_comb begin
        next_ctrl_sh = ctrl_sh;
        next_mask_sh = mask_sh;
        if (wr_ok && avs_address == atc_pkg::OFS_CTRL) next_ctrl_sh = avs_writedata[15:0];
        if (wr_ok && avs_address == atc_pkg::OFS_MASK) next_mask_sh = avs_writedata[1:0];
    end
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctrl_sh <= atc_pkg::RST_CTRL;
            mask_sh <= atc_pkg::RST_MASK;
        end else begin
            ctrl_sh <= next_ctrl_sh;
            mask_sh <= next_mask_sh;
        end
    end
    default clocking dc @(posedge clock); endclocking
    default disable iff (!nrst);
    wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request answered without a wait cycle");
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request waited more than one cycle");
    idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high while idle");
    rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    upper_zero_a: assert property (rd_ok |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read lanes not zero");
    hit_high_a: assert property (rd_ok && avs_address == atc_pkg::OFS_HIT_HIGH |->
        avs_readdata == 32'h0) else $error("absent hit channels read nonzero");
    gap_zero_a: assert property (rd_ok && avs_address > atc_pkg::OFS_MASK &&
        avs_address < atc_pkg::OFS_BUF |-> avs_readdata == 32'h0) else $error("unmapped read");
    module_on_a: assert property (module_on == ctrl_sh[7])
        else $error("module_on does not follow control");
    irq_mask_a: assert property (mask_sh == 2'h0 |-> !irq)
        else $error("irq high with all sources masked");
    seq_irq_a: assert property (ctrl_sh[0] && ctrl_sh[6:5] == 2'h3 && mask_sh[0] &&
        scan_end |=> irq) else $error("no irq at end of scan");
    cover property (wr_ok && avs_address == atc_pkg::OFS_CTRL && avs_writedata[0]);
    cover property (conv_valid && ctrl_sh[0] ##1 irq);
    cover property (scan_end ##1 irq);
endmodule : atc_threshold_props

// [tb/atc_threshold_test.sv]
`timescale 1ns/10ps
module atc_threshold_test;
    logic clock, nrst, avs_read, avs_write, avs_waitrequest, conv_valid, scan_end, module_on, irq;
    logic [6:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rng, rd;
    logic [3:0] avs_byteenable, conv_channel;
    logic [15:0] conv_value, m_hit, m_ctrl, side_val, lo;
    logic [15:0] m_buf [16];
    logic [1:0] m_st, m_mask;
    logic m_seq;
    int num_errors, samples_checked, m_cnt, side_ch, ch;

    atc_threshold uut (.clock(clock), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .conv_valid(conv_valid), .conv_channel(conv_channel),
        .conv_value(conv_value), .scan_end(scan_end), .module_on(module_on), .irq(irq));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    function automatic logic [15:0] xorshift();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[15:0];
    endfunction : xorshift

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    task automatic mconv(input int c, input logic [15:0] v, input logic se);
        int m;
        logic hit, up;
        m = (c + 9) % 16;
        up = v > m_buf[m];
        if (!m_ctrl[0] || m_ctrl[4:3] == 2'h0) begin
            m_buf[c] = v;
            if (!m_ctrl[0]) m_st[0] = m_st[0] | (m_cnt == int'(m_ctrl[13:9]));
            if (!m_ctrl[0]) m_cnt = (m_cnt == int'(m_ctrl[13:9])) ? 0 : m_cnt + 1;
            return;
        end
        case (m_ctrl[2:1])
            2'h0: hit = v < m_buf[c];
            2'h1: hit = v > m_buf[c];
            2'h2: hit = v > m_buf[c] && v < m_buf[m];
            default: hit = up || v < m_buf[c];
        endcase
        if (hit) begin
            m_hit[c] = 1'b1;
            if (m_ctrl[2:1] == 2'h3 && up) m_hit[m] = 1'b1;
            if (m_ctrl[4:3] == 2'h1 && m_ctrl[2:1] == 2'h3 && up) m_buf[m] = v;
            else if (m_ctrl[4:3] == 2'h1) m_buf[c] = v;
        end
        m_seq = m_seq | hit;
        if (m_ctrl[6:5] == 2'h1 && hit) m_st[0] = 1'b1;
        if (se && (m_ctrl[6:5] == 2'h3 || (m_ctrl[6:5] == 2'h2 && m_seq))) m_st[0] = 1'b1;
        if (se) m_seq = 1'b0;
    endtask : mconv

    task automatic bus(input logic w, input logic [6:0] a, input logic [15:0] d);
        int n;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= w;
        avs_read <= !w;
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (!avs_waitrequest) break;
            conv_valid <= side_ch >= 0;
            conv_channel <= side_ch[3:0];
            conv_value <= side_val;
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        conv_valid <= 1'b0;
        if (n == 20) num_errors++;
        if (n == 20) test_done();
        @(posedge clock);
    endtask : bus

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        if (a == 7'h00) m_ctrl = d;
        if (a == 7'h04) m_hit = m_hit & ~d;
        if (a == 7'h0c) m_st = m_st & ~d[1:0];
        if (a == 7'h10) m_mask = d[1:0];
        if (a >= 7'h40 && m_ctrl[7]) m_st[1] = 1'b1;
        if (a >= 7'h40 && !m_ctrl[7]) m_buf[a[5:2]] = d;
        if (side_ch >= 0) mconv(side_ch, side_val, 1'b0);
        bus(1'b1, a, d);
        side_ch = -1;
    endtask : wr

    task automatic rdc(input logic [6:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        check(rd, {16'h0000, e});
    endtask : rdc

    task automatic irqchk();
        @(negedge clock);
        check({31'h0, irq}, {31'h0, |(m_st & m_mask)});
        @(posedge clock);
    endtask : irqchk

    task automatic conv(input int c, input logic [15:0] v, input logic se);
        conv_valid <= 1'b1;
        conv_channel <= c[3:0];
        conv_value <= v;
        scan_end <= se;
        @(posedge clock);
        conv_valid <= 1'b0;
        scan_end <= 1'b0;
        mconv(c, v, se);
        @(posedge clock);
    endtask : conv

    initial begin
        {avs_read, avs_write, conv_valid, scan_end, nrst, m_seq} = 6'h00;
        {avs_address, avs_writedata, conv_channel, conv_value} = 59'h0;
        avs_byteenable = 4'hf;
        {m_hit, m_ctrl, m_st, m_mask, side_val} = 52'h0;
        foreach (m_buf[i]) m_buf[i] = 16'h0000;
        {num_errors, samples_checked, m_cnt, side_ch, rng} = {96'h0, -32'sd1, 32'd1824};
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        for (int a = 0; a < 128; a += 4) rdc(7'(a), 16'h0000);
        // Only the upper write lane is enabled, so the low byte must keep its old value.
        avs_byteenable <= 4'h2;
        bus(1'b1, 7'h48, 16'habcd);
        avs_byteenable <= 4'hf;
        m_buf[2] = 16'hab00;
        rdc(7'h48, m_buf[2]);
        $display("test reset values done");
        wr(7'h00, 16'h0400);
        wr(7'h10, 16'h0001);
        for (int i = 0; i < 6; i++) begin
            conv(i, xorshift(), 1'b0);
            irqchk();
            rdc(7'h0c, {14'h0, m_st});
            wr(7'h0c, 16'h0003);
            rdc(7'h40 + 7'(4 * i), m_buf[i]);
        end
        rdc(7'h04, m_hit);
        $display("test legacy done");
        wr(7'h00, 16'h0080);
        wr(7'h10, 16'h0002);
        wr(7'h44, 16'h1234);
        irqchk();
        rdc(7'h44, m_buf[1]);
        wr(7'h0c, 16'h0002);
        irqchk();
        $display("test refused write done");
        for (int k = 0; k < 8; k++) begin
            wr(7'h00, {8'h01, 3'h0, 2'(k / 4 + 1), 2'(k % 4), 1'b1});
            ch = xorshift() % 16;
            lo = xorshift() % 16'h4000 + 16'h2000;
            wr(7'h40 + 7'(4 * ch), lo);
            wr(7'h40 + 7'(4 * ((ch + 9) % 16)), lo + 16'h4000);
            repeat (4) conv(ch, xorshift(), 1'b0);
            rdc(7'h04, m_hit);
            rdc(7'h40 + 7'(4 * ch), m_buf[ch]);
            rdc(7'h40 + 7'(4 * ((ch + 9) % 16)), m_buf[(ch + 9) % 16]);
            wr(7'h04, 16'hffff);
        end
        $display("test compare modes done");
        for (int k = 0; k < 4; k++) begin
            wr(7'h00, {8'h01, 1'b0, 2'(k), 2'h2, 2'h1, 1'b1});
            rdc(7'h00, m_ctrl);
            wr(7'h10, 16'h0001);
            wr(7'h40, 16'h8000);
            wr(7'h44, 16'hffff);
            wr(7'h0c, 16'h0003);
            conv(0, 16'h0100, 1'b0);
            irqchk();
            conv(0, 16'hff00, 1'b0);
            irqchk();
            conv(1, 16'h0000, 1'b1);
            irqchk();
            rdc(7'h0c, {14'h0, m_st});
            wr(7'h04, 16'hffff);
        end
        $display("test irq modes done");
        wr(7'h00, 16'h0113);
        wr(7'h4c, 16'h0000);
        side_ch = 3;
        side_val = 16'h0010;
        wr(7'h04, 16'hffff);
        rdc(7'h04, m_hit);
        $display("test clear race done");
        test_done();
    end
endmodule : atc_threshold_test

bind atc_threshold atc_threshold_props chk (.clock(clock), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conv_valid(conv_valid),
    .conv_channel(conv_channel), .conv_value(conv_value), .scan_end(scan_end),
    .module_on(module_on), .irq(irq));
